// *** rtl/sope_pkg.sv ***
// Purpose: Shared constants and types for the serial output port expander
// Assumes: 32-bit port words, one serial link shared by all ports
// Notes:   Frame lengths are in bits, 4 to 32
package sope_pkg;

   // ==========================================================
   // Sizes
   localparam int PORT_BITS  = 32;
   localparam int HALF_BITS  = 16;
   localparam int CS_COUNT   = 6;
   localparam int CS_W       = 3;
   localparam int LEN_W      = 6;
   localparam int MAX_PORTS  = 4;

   // ==========================================================
   // Frame length limits and reset values
   localparam logic [LEN_W-1:0]     LEN_MIN       = 6'h04;
   localparam logic [LEN_W-1:0]     LEN_MAX       = 6'h20;
   localparam logic [PORT_BITS-1:0] PORT_RST_VAL  = 32'h0000_0000;
   // Chip select level between frames; idle high gives a rising
   // edge at frame end that latches the receiver storage stage
   localparam logic                 CS_IDLE_LEVEL = 1'b1;

   // ==========================================================
   // Frame request handed from the system side to the link side
   typedef struct packed {
      logic [PORT_BITS-1:0] data;
      logic [LEN_W-1:0]     len;
      logic [CS_W-1:0]      cs;
   } sope_frame_t;

   // Masked half write: upper 16 bits are the write enables
   typedef struct packed {
      logic [HALF_BITS-1:0] mask;
      logic [HALF_BITS-1:0] data;
   } sope_half_wr_t;

endpackage

// *** rtl/sope_expander.sv ***
// Purpose: Serial output port expander; port registers streamed to an
//          external chain of double-buffered shift registers
// Assumes: i_lnk_clk runs free; serial clock is half the link clock
// Notes:   Bits go out least significant first; one link shared by ports
module sope_expander #(
   parameter int NUM_PORTS = sope_pkg::MAX_PORTS
) (
   // System clock and reset
   input  wire logic                                  i_clk,
   input  wire logic                                  i_rst_n,
   // Link clock
   input  wire logic                                  i_lnk_clk,
   // Control
   input  wire logic                                  i_enable,
   input  wire logic                                  i_sw_clear,
   input  wire logic [sope_pkg::LEN_W-1:0]            i_frame_len,
   input  wire logic [NUM_PORTS-1:0][sope_pkg::CS_W-1:0] i_port_cs,
   // Port writes
   input  wire logic                                  i_wr_valid,
   input  wire logic [1:0]                            i_wr_port,
   input  wire logic                                  i_wr_upper,
   input  wire sope_pkg::sope_half_wr_t               i_wr_half,
   // Status
   output logic [NUM_PORTS-1:0][sope_pkg::PORT_BITS-1:0] o_port_val,
   output logic [NUM_PORTS-1:0]                       o_pending,
   output logic                                       o_busy,
   // Serial link
   output logic                                       o_sclk,
   output logic                                       o_sdata,
   output logic [sope_pkg::CS_COUNT-1:0]              o_cs_n,
   input  wire logic                                  i_sdata_in,
   // Receiver clears
   output logic                                       o_shift_clr_n,
   output logic                                       o_store_clr_n
);

   // ==========================================================
   // Helpers
   function automatic logic [sope_pkg::HALF_BITS-1:0] merge_half(
      input logic [sope_pkg::HALF_BITS-1:0] old_v,
      input sope_pkg::sope_half_wr_t        wr
   );
      merge_half = (old_v & ~wr.mask) | (wr.data & wr.mask);
   endfunction

   function automatic logic [sope_pkg::LEN_W-1:0] clamp_len(
      input logic [sope_pkg::LEN_W-1:0] len
   );
      if (len < sope_pkg::LEN_MIN) begin
         clamp_len = sope_pkg::LEN_MIN;
      end else if (len > sope_pkg::LEN_MAX) begin
         clamp_len = sope_pkg::LEN_MAX;
      end else begin
         clamp_len = len;
      end
   endfunction

   // ==========================================================
   // Port registers and pending flags
   logic [NUM_PORTS-1:0][sope_pkg::PORT_BITS-1:0] port_q;
   logic [NUM_PORTS-1:0]                          pend_q;
   logic [NUM_PORTS-1:0]                          take;
   logic                                          launch;
   logic [1:0]                                    sel;

   genvar gp;
   generate
      for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
         logic hit;
         assign hit = i_wr_valid && (i_wr_port == 2'(gp));

         always_ff @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               port_q[gp] <= sope_pkg::PORT_RST_VAL;
            end else if (hit) begin
               if (i_wr_upper) begin
                  port_q[gp][31:16] <= merge_half(port_q[gp][31:16], i_wr_half);
               end else begin
                  port_q[gp][15:0] <= merge_half(port_q[gp][15:0], i_wr_half);
               end
            end
         end

         // A write landing in the launch cycle keeps the flag set
         always_ff @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               pend_q[gp] <= 1'b0;
            end else if (hit) begin
               pend_q[gp] <= 1'b1;
            end else if (take[gp]) begin
               pend_q[gp] <= 1'b0;
            end
         end
      end
   endgenerate

   // ==========================================================
   // Launch arbitration: lowest pending port wins
   logic busy_q;

   always_comb begin
      sel  = 2'h0;
      take = '0;
      for (int i = NUM_PORTS - 1; i >= 0; i--) begin
         if (pend_q[i]) begin
            sel = i[1:0];
         end
      end
      launch = i_enable && !busy_q && (|pend_q);
      if (launch) begin
         take[sel] = 1'b1;
      end
   end

   // ==========================================================
   // System to link handshake; frame word held stable while busy
   sope_pkg::sope_frame_t frame_q;
   logic                  req_tgl_q;
   logic                  done_tgl_q;
   logic [2:0]            done_sync_q;
   logic                  done_evt;

   assign done_evt = done_sync_q[1] ^ done_sync_q[2];

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         frame_q   <= '0;
         req_tgl_q <= 1'b0;
      end else if (launch) begin
         frame_q.data <= port_q[sel];
         frame_q.len  <= clamp_len(i_frame_len);
         frame_q.cs   <= i_port_cs[sel];
         req_tgl_q    <= ~req_tgl_q;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         busy_q <= 1'b0;
      end else if (launch) begin
         busy_q <= 1'b1;
      end else if (done_evt) begin
         busy_q <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         done_sync_q <= '0;
      end else begin
         done_sync_q <= {done_sync_q[1:0], done_tgl_q};
      end
   end

   // ==========================================================
   // Status and receiver clear outputs
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_port_val    <= '0;
         o_pending     <= '0;
         o_busy        <= 1'b0;
         o_shift_clr_n <= 1'b0;
         o_store_clr_n <= 1'b0;
      end else begin
         o_port_val    <= port_q;
         o_pending     <= pend_q;
         o_busy        <= busy_q;
         o_shift_clr_n <= ~i_sw_clear;
         o_store_clr_n <= ~i_sw_clear;
      end
   end

   // ==========================================================
   // Link side: serial shifter on the link clock
   typedef enum logic [2:0] {
      L_IDLE,
      L_LEAD,
      L_HIGH,
      L_LOW,
      L_TAIL
   } sope_lstate_t;

   sope_lstate_t                     lst_q;
   logic [2:0]                       req_sync_q;
   logic                             req_evt;
   logic [sope_pkg::PORT_BITS-1:0]   shreg_q;
   logic [sope_pkg::LEN_W-1:0]       len_q;
   logic [sope_pkg::LEN_W-1:0]       cnt_q;
   logic [sope_pkg::CS_W-1:0]        cs_sel_q;
   logic                             last_bit;

   assign req_evt  = req_sync_q[1] ^ req_sync_q[2];
   assign last_bit = (cnt_q == len_q - 6'h01);

   always_ff @(posedge i_lnk_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         req_sync_q <= '0;
      end else begin
         req_sync_q <= {req_sync_q[1:0], req_tgl_q};
      end
   end

   always_ff @(posedge i_lnk_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         lst_q      <= L_IDLE;
         shreg_q    <= '0;
         len_q      <= sope_pkg::LEN_MIN;
         cnt_q      <= '0;
         cs_sel_q   <= '0;
         done_tgl_q <= 1'b0;
      end else begin
         case (lst_q)
            L_IDLE: begin
               if (req_evt) begin
                  // Frame word was written on the same edge as the toggle and has been stable since
                  shreg_q  <= frame_q.data;
                  len_q    <= frame_q.len;
                  cs_sel_q <= frame_q.cs;
                  cnt_q    <= '0;
                  lst_q    <= L_LEAD;
               end
            end
            L_LEAD: begin
               lst_q <= L_HIGH;
            end
            L_HIGH: begin
               lst_q <= last_bit ? L_TAIL : L_LOW;
            end
            L_LOW: begin
               shreg_q <= {1'b0, shreg_q[sope_pkg::PORT_BITS-1:1]};
               cnt_q   <= cnt_q + 6'h01;
               lst_q   <= L_HIGH;
            end
            L_TAIL: begin
               done_tgl_q <= ~done_tgl_q;
               lst_q      <= L_IDLE;
            end
            default: begin
               lst_q <= L_IDLE;
            end
         endcase
      end
   end

   // Pin drivers registered so each pin comes from a flop
   always_ff @(posedge i_lnk_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_sclk  <= 1'b0;
         o_sdata <= 1'b0;
         o_cs_n  <= {sope_pkg::CS_COUNT{sope_pkg::CS_IDLE_LEVEL}};
      end else begin
         o_cs_n <= {sope_pkg::CS_COUNT{sope_pkg::CS_IDLE_LEVEL}};
         o_sclk <= 1'b0;
         case (lst_q)
            L_LEAD, L_TAIL: begin
               o_cs_n[cs_sel_q] <= ~sope_pkg::CS_IDLE_LEVEL;
               o_sdata          <= shreg_q[0];
            end
            L_LOW: begin
               // Word shifts on this same edge, so present the next bit now
               o_cs_n[cs_sel_q] <= ~sope_pkg::CS_IDLE_LEVEL;
               o_sdata          <= shreg_q[1];
            end
            L_HIGH: begin
               o_cs_n[cs_sel_q] <= ~sope_pkg::CS_IDLE_LEVEL;
               // No clock when the chip select index selects nothing
               o_sclk <= (cs_sel_q < 3'(sope_pkg::CS_COUNT));
            end
            default: begin
               // Chip select returns high here: this edge latches the receiver
               o_sdata <= o_sdata;
            end
         endcase
      end
   end

   // Return data never carries anything useful
   logic unused_in;
   assign unused_in = i_sdata_in;

endmodule

// *** testbench/sope_expander_properties.sv ***
// Purpose: Link and write-side checks for the port expander
// Assumes: Frame length held steady while frames run
// Notes:   Bound onto every expander instance
module sope_expander_properties #(
   parameter int NUM_PORTS = 4
) (
   input wire logic                 i_clk,
   input wire logic                 i_rst_n,
   input wire logic                 i_lnk_clk,
   input wire logic                 i_enable,
   input wire logic                 i_sw_clear,
   input wire logic [5:0]           i_frame_len,
   input wire logic                 i_wr_valid,
   input wire logic [NUM_PORTS-1:0] o_pending,
   input wire logic                 o_busy,
   input wire logic                 o_sclk,
   input wire logic                 o_sdata,
   input wire logic [5:0]           o_cs_n,
   input wire logic                 o_shift_clr_n,
   input wire logic                 o_store_clr_n
);
   // ==========================================
   // Serial clock highs counted over one frame
   logic [6:0] cnt_q;
   logic [5:0] len_c;
   assign len_c = i_frame_len < 6'h04 ? 6'h04 : (i_frame_len > 6'h20 ? 6'h20 : i_frame_len);
   always_ff @(posedge i_lnk_clk or negedge i_rst_n) begin
      if (!i_rst_n) cnt_q <= 7'h00;
      else if (&o_cs_n) cnt_q <= 7'h00;
      else cnt_q <= cnt_q + {6'h00, o_sclk};
   end
   // ==========================================
   // Link side
   a_sclk_idle: assert property (@(posedge i_lnk_clk) disable iff (!i_rst_n)
      &o_cs_n |-> !o_sclk) else $error("sclk runs while deselected");
   a_sdata_hold: assert property (@(posedge i_lnk_clk) disable iff (!i_rst_n)
      o_sclk |-> $stable(o_sdata)) else $error("sdata moved off a falling edge");
   a_one_select: assert property (@(posedge i_lnk_clk) disable iff (!i_rst_n)
      $onehot0(~o_cs_n)) else $error("two chip selects low");
   a_latch_edge: assert property (@(posedge i_lnk_clk) disable iff (!i_rst_n)
      $rose(&o_cs_n) |-> !o_sclk && !$past(o_sclk)) else $error("frame end not clean");
   a_frame_len: assert property (@(posedge i_lnk_clk) disable iff (!i_rst_n)
      $rose(&o_cs_n) |-> cnt_q == {1'b0, len_c}) else $error("wrong bit count");
   // ==========================================
   // System side
   a_write_launch: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_wr_valid |-> ##[1:4] (|o_pending || o_busy)) else $error("write ignored");
   a_no_launch: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !i_enable [*3] ##0 !o_busy |=> !o_busy) else $error("frame while disabled");
   a_clear_on: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_sw_clear |=> !o_shift_clr_n && !o_store_clr_n) else $error("clear not driven");
   c_frame: cover property (@(posedge i_lnk_clk) $rose(&o_cs_n));
   c_merge: cover property (@(posedge i_clk) o_busy && |o_pending);
   c_clear: cover property (@(posedge i_clk) i_sw_clear);
endmodule

bind sope_expander sope_expander_properties #(.NUM_PORTS(NUM_PORTS)) u_props (
   .i_clk, .i_rst_n, .i_lnk_clk, .i_enable, .i_sw_clear, .i_frame_len, .i_wr_valid,
   .o_pending, .o_busy, .o_sclk, .o_sdata, .o_cs_n, .o_shift_clr_n, .o_store_clr_n);

// *** testbench/sope_shift_chain.sv ***
// Purpose: Four chained 8-bit double-buffered shift stages
// Assumes: Idle-low serial clock, chip select as latch clock
// Notes: Drives nothing back toward the master
module sope_shift_chain (
   input  wire logic        i_sclk,
   input  wire logic        i_sdata,
   input  wire logic        i_latch,
   input  wire logic        i_shift_clr_n,
   input  wire logic        i_store_clr_n,
   output logic [31:0]      o_par,
   output logic             o_cascade
);
   logic [31:0] shift_q;
   // Bit 0 is the far end of the chain of four stages
   always_ff @(posedge i_sclk or negedge i_shift_clr_n) begin
      if (!i_shift_clr_n) shift_q <= 32'h0;
      else if (!i_latch) shift_q <= {i_sdata, shift_q[31:1]};
   end
   // Outputs hold the old word until the latch edge
   always_ff @(posedge i_latch or negedge i_store_clr_n) begin
      if (!i_store_clr_n) o_par <= 32'h0;
      else o_par <= shift_q;
   end
   assign o_cascade = shift_q[0];
endmodule

// *** testbench/test_serial_output_port_expander.sv ***
// Purpose: Self-checking bench for the port expander
// Assumes: Two receiver chains, on chip selects 0 and 3
// Notes:   Expected words are kept in a local shadow
module test_serial_output_port_expander;
   timeunit 1ns;
   timeprecision 1ps;
   logic                          i_clk = 1'b0, i_lnk_clk = 1'b0, i_rst_n, i_enable;
   logic                          i_sw_clear, i_wr_valid, i_wr_upper, i_sdata_in = 1'b0;
   logic                          o_busy, o_sclk, o_sdata, o_shift_clr_n, o_store_clr_n;
   logic [5:0]                    i_frame_len, o_cs_n;
   logic [3:0][2:0]               i_port_cs;
   logic [1:0]                    i_wr_port;
   sope_pkg::sope_half_wr_t       i_wr_half;
   logic [3:0][31:0]              o_port_val;
   logic [3:0]                    o_pending;
   logic [31:0]                   par0, par1, exp_v [4];
   int                            num_errors = 0, samples_checked = 0;
   sope_expander DUT (.i_clk, .i_rst_n, .i_lnk_clk, .i_enable, .i_sw_clear, .i_frame_len,
      .i_port_cs, .i_wr_valid, .i_wr_port, .i_wr_upper, .i_wr_half, .o_port_val,
      .o_pending, .o_busy, .o_sclk, .o_sdata, .o_cs_n, .i_sdata_in, .o_shift_clr_n,
      .o_store_clr_n);
   sope_shift_chain u_chain0 (.i_sclk(o_sclk), .i_sdata(o_sdata), .i_latch(o_cs_n[0]),
      .i_shift_clr_n(o_shift_clr_n), .i_store_clr_n(o_store_clr_n), .o_par(par0),
      .o_cascade());
   sope_shift_chain u_chain1 (.i_sclk(o_sclk), .i_sdata(o_sdata), .i_latch(o_cs_n[3]),
      .i_shift_clr_n(o_shift_clr_n), .i_store_clr_n(o_store_clr_n), .o_par(par1),
      .o_cascade());
   always #12.5 i_clk = ~i_clk;
   initial begin
      #3.1;
      forever #7.5 i_lnk_clk = ~i_lnk_clk;
   end
   // No receiver chain drives the return line; keep it moving so nothing leans on it
   always @(negedge i_clk) i_sdata_in <= ~i_sdata_in;
   // ==========================================
   // Shared tasks
   task automatic check(input string what, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [1:0] p, input logic up, input logic [15:0] m, d);
      logic [31:0] mw;
      mw = up ? {m, 16'h0} : {16'h0, m};
      exp_v[p] = (exp_v[p] & ~mw) | ((up ? {d, 16'h0} : {16'h0, d}) & mw);
      @(negedge i_clk);
      i_wr_valid = 1'b1;
      i_wr_port = p;
      i_wr_upper = up;
      i_wr_half = {m, d};
      @(negedge i_clk);
      i_wr_valid = 1'b0;
   endtask
   // Writer waits for the frame to drain before going on
   task automatic settle();
      int n;
      n = 0;
      repeat (6) @(negedge i_clk);
      while ((o_busy !== 1'b0 || o_pending !== 4'h0) && n < 3000) begin
         @(negedge i_clk);
         n++;
      end
      check("drain", 32'(n >= 3000), 32'h0);
      repeat (2) @(negedge i_clk);
   endtask
   task automatic wr_chk(input logic [15:0] m, d, input logic up);
      wr(2'h0, up, m, d);
      settle();
      check("port reg", o_port_val[0], exp_v[0]);
      check("receiver", par0, exp_v[0]);
   endtask
   // ==========================================
   // Scenarios
   task automatic t_merge();
      wr(2'h0, 1'b1, 16'hffff, 16'ha5a5);
      repeat (8) @(negedge i_clk);
      wr(2'h0, 1'b0, 16'hffff, 16'h1234);
      wr(2'h0, 1'b0, 16'hff00, 16'hffff);
      @(negedge i_clk);
      check("held update", 32'({o_busy, o_pending[0]}), 32'h3);
      settle();
      check("merged", par0, exp_v[0]);
   endtask
   task automatic t_disabled();
      i_enable = 1'b0;
      wr(2'h1, 1'b0, 16'hffff, 16'hbeef);
      repeat (20) @(negedge i_clk);
      check("idle", 32'({o_busy, o_pending[1]}), 32'h1);
      check("no frame", par1, 32'h0);
      i_enable = 1'b1;
      settle();
      check("chain1", par1, exp_v[1]);
      check("chain0", par0, exp_v[0]);
   endtask
   task automatic t_lengths();
      logic [5:0] lens [3];
      int n;
      lens = '{6'h03, 6'h08, 6'h21};
      foreach (lens[i]) begin
         i_sw_clear = 1'b1;
         repeat (3) @(negedge i_clk);
         check("clears", 32'({o_shift_clr_n, o_store_clr_n}), 32'h0);
         check("cleared", par0, 32'h0);
         i_sw_clear = 1'b0;
         i_frame_len = lens[i];
         repeat (3) @(negedge i_clk);
         wr(2'h0, 1'b0, 16'hffff, 16'h00a5 + 16'(i));
         settle();
         n = lens[i] < 6'h04 ? 4 : (lens[i] > 6'h20 ? 32 : int'(lens[i]));
         check("short frame", par0, exp_v[0] << (32 - n));
      end
      i_frame_len = 6'h20;
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // ==========================================
   // Main sequence and watchdog
   initial begin
      {i_rst_n, i_sw_clear, i_wr_valid, i_wr_upper, i_wr_port} = '0;
      i_enable = 1'b1;
      i_frame_len = 6'h20;
      i_port_cs = {3'h5, 3'h4, 3'h3, 3'h0};
      i_wr_half = '0;
      exp_v = '{4{32'h0}};
      repeat (10) @(negedge i_clk);
      check("cs idle", 32'(o_cs_n), 32'h3f);
      check("reset clears", 32'({o_shift_clr_n, o_store_clr_n}), 32'h0);
      i_rst_n = 1'b1;
      repeat (3) @(negedge i_clk);
      wr_chk(16'hffff, 16'h5555, 1'b1);
      wr_chk(16'hffff, 16'h0ff0, 1'b0);
      wr_chk(16'h00ff, 16'hffff, 1'b0);
      t_merge();
      t_disabled();
      t_lengths();
      finish_test();
   end
   initial begin
      repeat (20000) @(posedge i_clk);
      $display("wrong value watchdog expected done seen hang");
      num_errors++;
      finish_test();
   end
endmodule
